/* logic/mcb_pkg.sv */
package mcb_pkg;

    localparam logic [7:0]  CTRL_OFS         = 8'h00;
    localparam logic [7:0]  DIV_OFS          = 8'h04;
    localparam logic [7:0]  PHASE_OFS        = 8'h08;
    localparam logic [7:0]  STATUS_OFS       = 8'h0C;

    localparam int          CTRL_CHOICE_BIT  = 0;
    localparam int          CTRL_SE_A_BIT    = 1;
    localparam int          CTRL_SE_B_BIT    = 2;
    localparam int          CTRL_MODE_LSB    = 3;
    localparam int          CTRL_FS_LSB      = 5;
    localparam int          CTRL_OFF_LSB     = 7;

    localparam int          DIV_B1_LSB       = 0;
    localparam int          DIV_B2_LSB       = 4;
    localparam int          DIV_FB_LSB       = 8;

    localparam int          PH_1F0_LSB       = 0;
    localparam int          PH_1F1_LSB       = 2;
    localparam int          PH_1F2_LSB       = 4;
    localparam int          PH_1F3_LSB       = 6;
    localparam int          PH_2F0_LSB       = 8;
    localparam int          PH_2F1_LSB       = 10;
    localparam int          PH_RETURN_PHASE_SELECT_LSB      = 12;

    localparam int          STATUS_LOCK_BIT  = 0;
    localparam int          STATUS_UNIT_LSB  = 8;

    localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
    localparam logic [31:0] DIV_RESET        = 32'h0000_0000;
    localparam logic [31:0] PHASE_RESET      = 32'h0000_1555;
    localparam logic [31:0] CTRL_MASK        = 32'h0000_01FF;
    localparam logic [31:0] DIV_MASK         = 32'h0000_0FFF;
    localparam logic [31:0] PHASE_MASK       = 32'h0000_3FFF;

    localparam int          PERIOD_W         = 9;
    localparam int          OFFSET_W         = 5;
    localparam int          GROUPS           = 4;

    localparam logic [5:0]  N_LOW            = 6'h20;
    localparam logic [5:0]  N_MID            = 6'h10;
    localparam logic [5:0]  N_HIGH           = 6'h08;

    typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} mcb_level_t;

    function automatic mcb_level_t decode_level(input logic [1:0] code);
        case (code)
            2'h0:    decode_level = LVL_LOW;
            2'h2:    decode_level = LVL_HIGH;
            default: decode_level = LVL_MID;
        endcase
    endfunction

    function automatic logic [3:0] pair_index(input logic [1:0] hi, input logic [1:0] lo);
        logic [3:0] h;
        logic [3:0] l;
        h = {2'h0, decode_level(hi)};
        l = {2'h0, decode_level(lo)};
        pair_index = 4'((h << 1) + h + l);
    endfunction

    function automatic logic [3:0] divide_ratio(input logic [3:0] idx);
        case (idx)
            4'h6:    divide_ratio = 4'h8;
            4'h7:    divide_ratio = 4'hA;
            4'h8:    divide_ratio = 4'hC;
            default: divide_ratio = 4'(idx + 4'h1);
        endcase
    endfunction

    function automatic logic signed [OFFSET_W-1:0] bank1_phase(input logic [3:0] idx);
        bank1_phase = OFFSET_W'($signed({1'b0, idx}) - 5'sh04);
    endfunction

    function automatic logic signed [OFFSET_W-1:0] bank2_phase(input logic [3:0] idx,
                                                             input logic signed [OFFSET_W-1:0] g1,
                                                             input logic signed [OFFSET_W-1:0] g2);
        case (idx)
            4'h0:    bank2_phase = -5'sh08;
            4'h1:    bank2_phase = -5'sh07;
            4'h2:    bank2_phase = -5'sh06;
            4'h3:    bank2_phase = g1;
            4'h5:    bank2_phase = g2;
            4'h6:    bank2_phase = 5'sh06;
            4'h7:    bank2_phase = 5'sh07;
            4'h8:    bank2_phase = 5'sh08;
            default: bank2_phase = 5'sh00;
        endcase
    endfunction

    function automatic logic signed [OFFSET_W-1:0] return_phase(input mcb_level_t lvl);
        case (lvl)
            LVL_LOW:  return_phase = -5'sh04;
            LVL_HIGH: return_phase = 5'sh04;
            default:  return_phase = 5'sh00;
        endcase
    endfunction

    function automatic logic [5:0] n_factor(input mcb_level_t fs);
        case (fs)
            LVL_LOW:  n_factor = N_LOW;
            LVL_HIGH: n_factor = N_HIGH;
            default:  n_factor = N_MID;
        endcase
    endfunction

endpackage

/* logic/mcb_phase_gen.sv */
`timescale 1ns/10ps
module mcb_phase_gen #(
    parameter int PW = mcb_pkg::PERIOD_W,
    parameter int OW = mcb_pkg::OFFSET_W
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 unit_tick,
    input  wire logic                 restart,
    input  wire logic [PW-1:0]        period,
    input  wire logic signed [OW-1:0] offset,
    output logic                      level
);
    localparam int W = PW + 2;

    logic [PW-1:0] pos_r;
    logic [PW-1:0] pos_nxt;
    logic [W-1:0]  base;
    logic [W-1:0]  shifted;
    logic [W-1:0]  red1;
    logic [W-1:0]  red2;
    logic          level_nxt;

    // offset never exceeds the shortest period, so two reductions suffice
    assign base      = W'(pos_r) + W'(period);
    assign shifted   = base - W'(offset);
    assign red1      = (shifted >= W'(period)) ? shifted - W'(period) : shifted;
    assign red2      = (red1 >= W'(period)) ? red1 - W'(period) : red1;
    assign level_nxt = red2 < W'(period >> 1);
    assign pos_nxt   = restart ? '0
                     : !unit_tick ? pos_r
                     : (pos_r >= period - PW'(1)) ? '0
                     : pos_r + PW'(1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pos_r <= '0;
            level <= 1'b0;
        end
        else
        begin
            pos_r <= pos_nxt;
            level <= level_nxt;
        end
    end

endmodule // mcb_phase_gen

/* logic/mcb_clock_bank_ctrl.sv */
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// - choice low uses the primary pair, high uses the secondary pair
// - reference choice defaults low, so primary pair after reset
// - loop tunes output so return edges meet selected reference edges
// - bank off bit disables all bank outputs, state chosen by mode
// - bank not off drives its clocks at selected frequency and phase
// - mode high: disabled outputs go high impedance
// - mode low: disabled outputs are parked low, still driven
// - mode middle selects factory test mode
// - lock indicator high when locked, low while acquiring
// - ten outputs: bank one of four, bank two of six
// - divide ratios one to six, eight, ten, twelve
// - return output divider set by its own select pair
// - return output phase set by one select, three positions
// - each phase select pair sets its own group offset
// - each bank divider pair sets its own bank ratio
// - switching to secondary pair keeps loop tuning for smooth changeover
// - divider pairs decode high digit first to the ratio table
// - phase pairs map to the bank one and bank two tables, the return select to the return table
// - skew unit is nominal period over 32, 16 or 8 by range
module mcb_clock_bank_ctrl #(
    parameter int UNIT_LEN_W    = 8,
    parameter int UNIT_LEN_INIT = 8,
    parameter int LOCK_COUNT    = 8,
    parameter int LOCK_WINDOW   = 2,
    parameter int EDGE_TIMEOUT  = 4096
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        primary_reference_true,
    input  wire logic        primary_reference_comp,
    input  wire logic        secondary_reference_true,
    input  wire logic        secondary_reference_comp,
    input  wire logic        loop_return_input,
    output logic      [3:0]  bank1_clock_outputs,
    output logic      [3:0]  bank1_clock_outputs_oe,
    output logic      [5:0]  bank2_clock_outputs,
    output logic      [5:0]  bank2_clock_outputs_oe,
    output logic             return_clock_output,
    output logic             return_clock_output_oe,
    output logic             loop_acquired
);
    localparam int TW = $clog2(EDGE_TIMEOUT + 1);
    localparam int LW = $clog2(LOCK_COUNT + 1);
    localparam int PW = mcb_pkg::PERIOD_W;
    localparam int OW = mcb_pkg::OFFSET_W;

    generate
        if (UNIT_LEN_INIT < 1 || UNIT_LEN_INIT >= (1 << UNIT_LEN_W) || LOCK_COUNT < 1
            || LOCK_WINDOW < 0 || EDGE_TIMEOUT <= LOCK_WINDOW)
        begin : g_bad_params
            $error("mcb_clock_bank_ctrl: parameter values out of range");
        end
    endgenerate

    typedef enum logic [1:0] {PD_IDLE, PD_REF_FIRST, PD_RET_FIRST} mcb_pd_state_t;
    logic [31:0]           ctrl_r;
    logic [31:0]           div_r;
    logic [31:0]           phase_r;
    logic [UNIT_LEN_W-1:0] unit_len_r;
    logic [UNIT_LEN_W-1:0] unit_len_nxt;
    logic [UNIT_LEN_W-1:0] ucnt_r;
    logic [TW-1:0]         wcnt_r;
    logic [TW-1:0]         wcnt_nxt;
    logic [LW-1:0]         good_r;
    logic [LW-1:0]         good_nxt;
    logic                  lock_nxt;
    mcb_pd_state_t         pd_r;
    mcb_pd_state_t         pd_nxt;
    logic                  ref_prev_r;
    logic                  ret_prev_r;
    logic                  choice_prev_r;
    logic [4*PW-1:0]       period_prev_r;

    wire                   setup_ph   = psel & ~penable;
    wire                   wr_take    = psel & penable & pready & pwrite;
    wire                   hit_ctrl   = paddr == mcb_pkg::CTRL_OFS;
    wire                   hit_div    = paddr == mcb_pkg::DIV_OFS;
    wire                   hit_phase  = paddr == mcb_pkg::PHASE_OFS;
    wire                   hit_status = paddr == mcb_pkg::STATUS_OFS;
    wire                   mapped     = hit_ctrl | hit_div | hit_phase | hit_status;
    wire                   ro_write   = hit_status & pwrite;
    wire [31:0]            status_w   = (32'(unit_len_r) << mcb_pkg::STATUS_UNIT_LSB)
                                      | (32'(loop_acquired) << mcb_pkg::STATUS_LOCK_BIT);
    wire [31:0]            rd_sel     = hit_ctrl  ? ctrl_r
                                      : hit_div   ? div_r
                                      : hit_phase ? phase_r
                                      : hit_status ? status_w : 32'h0000_0000;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
        merge = (old & ~m) | (wd & m);
    endfunction

    wire                   choice   = ctrl_r[mcb_pkg::CTRL_CHOICE_BIT];
    wire                   ref_a    = primary_reference_true
                                    & (ctrl_r[mcb_pkg::CTRL_SE_A_BIT] | ~primary_reference_comp);
    wire                   ref_b    = secondary_reference_true
                                    & (ctrl_r[mcb_pkg::CTRL_SE_B_BIT] | ~secondary_reference_comp);
    wire                   ref_sel  = choice ? ref_b : ref_a;
    wire                   ref_rise = ref_sel & ~ref_prev_r;
    wire                   ret_rise = loop_return_input & ~ret_prev_r;
    wire                   switched = choice != choice_prev_r;
    mcb_pkg::mcb_level_t   fs_lvl;
    mcb_pkg::mcb_level_t   mode_lvl;
    mcb_pkg::mcb_level_t   fbf_lvl;
    assign fs_lvl   = mcb_pkg::decode_level(ctrl_r[mcb_pkg::CTRL_FS_LSB +: 2]);
    assign mode_lvl = mcb_pkg::decode_level(ctrl_r[mcb_pkg::CTRL_MODE_LSB +: 2]);
    assign fbf_lvl  = mcb_pkg::decode_level(phase_r[mcb_pkg::PH_RETURN_PHASE_SELECT_LSB +: 2]);
    wire [5:0]             n_fac    = mcb_pkg::n_factor(fs_lvl);
    wire [3:0]             b1_idx   = mcb_pkg::pair_index(div_r[mcb_pkg::DIV_B1_LSB + 2 +: 2],
                                                          div_r[mcb_pkg::DIV_B1_LSB +: 2]);
    wire [3:0]             b2_idx   = mcb_pkg::pair_index(div_r[mcb_pkg::DIV_B2_LSB + 2 +: 2],
                                                          div_r[mcb_pkg::DIV_B2_LSB +: 2]);
    wire [3:0]             fb_idx   = mcb_pkg::pair_index(div_r[mcb_pkg::DIV_FB_LSB + 2 +: 2],
                                                          div_r[mcb_pkg::DIV_FB_LSB +: 2]);
    wire [3:0]             ph1_idx  = mcb_pkg::pair_index(phase_r[mcb_pkg::PH_1F1_LSB +: 2],
                                                          phase_r[mcb_pkg::PH_1F0_LSB +: 2]);
    wire [3:0]             ph2_idx  = mcb_pkg::pair_index(phase_r[mcb_pkg::PH_1F3_LSB +: 2],
                                                          phase_r[mcb_pkg::PH_1F2_LSB +: 2]);
    wire [3:0]             ph3_idx  = mcb_pkg::pair_index(phase_r[mcb_pkg::PH_2F1_LSB +: 2],
                                                          phase_r[mcb_pkg::PH_2F0_LSB +: 2]);
    logic [PW-1:0]           period_g [mcb_pkg::GROUPS];
    logic signed [OW-1:0]    offset_g [mcb_pkg::GROUPS];
    logic [mcb_pkg::GROUPS-1:0] level_g;
    logic [4*PW-1:0]         period_cat;
    assign period_g[0] = PW'(n_fac * mcb_pkg::divide_ratio(b1_idx));
    assign period_g[1] = period_g[0];
    assign period_g[2] = PW'(n_fac * mcb_pkg::divide_ratio(b2_idx));
    assign period_g[3] = PW'(n_fac * mcb_pkg::divide_ratio(fb_idx));
    assign offset_g[0] = mcb_pkg::bank1_phase(ph1_idx);
    assign offset_g[1] = mcb_pkg::bank1_phase(ph2_idx);
    assign offset_g[2] = mcb_pkg::bank2_phase(ph3_idx, offset_g[0], offset_g[1]);
    assign offset_g[3] = mcb_pkg::return_phase(fbf_lvl);
    assign period_cat  = {period_g[3], period_g[2], period_g[1], period_g[0]};
    wire                   unit_tick = ucnt_r >= unit_len_r - UNIT_LEN_W'(1);
    wire                   restart   = period_cat != period_prev_r;
    genvar gi;
    generate
        for (gi = 0; gi < mcb_pkg::GROUPS; gi++)
        begin : g_grp
            mcb_phase_gen #(.PW (PW), .OW (OW)) u_gen (
                .pclk      (pclk),
                .presetn   (presetn),
                .unit_tick (unit_tick),
                .restart   (restart),
                .period    (period_g[gi]),
                .offset    (offset_g[gi]),
                .level     (level_g[gi])
            );
        end
    endgenerate
    always_comb
    begin
        pd_nxt       = pd_r;
        wcnt_nxt     = (wcnt_r < TW'(EDGE_TIMEOUT)) ? wcnt_r + TW'(1) : wcnt_r;
        unit_len_nxt = unit_len_r;
        good_nxt     = good_r;
        case (pd_r)
            PD_IDLE:
            begin
                wcnt_nxt = '0;
                if (ref_rise && ret_rise)
                    good_nxt = (good_r < LW'(LOCK_COUNT)) ? good_r + LW'(1) : good_r;
                else if (ref_rise)
                    pd_nxt = PD_REF_FIRST;
                else if (ret_rise)
                    pd_nxt = PD_RET_FIRST;
            end
            PD_REF_FIRST:
            begin
                if (ret_rise && wcnt_r <= TW'(LOCK_WINDOW))
                begin
                    pd_nxt   = PD_IDLE;
                    good_nxt = (good_r < LW'(LOCK_COUNT)) ? good_r + LW'(1) : good_r;
                end
                else if (ret_rise || ref_rise || wcnt_r >= TW'(EDGE_TIMEOUT))
                begin
                    // return too late: shorten the unit to speed the outputs
                    pd_nxt   = ret_rise ? PD_IDLE : pd_r;
                    wcnt_nxt = '0;
                    good_nxt = '0;
                    if (unit_len_r > UNIT_LEN_W'(1))
                        unit_len_nxt = unit_len_r - UNIT_LEN_W'(1);
                end
            end
            PD_RET_FIRST:
            begin
                if (ref_rise && wcnt_r <= TW'(LOCK_WINDOW))
                begin
                    pd_nxt   = PD_IDLE;
                    good_nxt = (good_r < LW'(LOCK_COUNT)) ? good_r + LW'(1) : good_r;
                end
                else if (ref_rise || ret_rise || wcnt_r >= TW'(EDGE_TIMEOUT))
                begin
                    // return too early: lengthen the unit to slow the outputs
                    pd_nxt   = ref_rise ? PD_IDLE : pd_r;
                    wcnt_nxt = '0;
                    good_nxt = '0;
                    if (unit_len_r < {UNIT_LEN_W{1'b1}})
                        unit_len_nxt = unit_len_r + UNIT_LEN_W'(1);
                end
            end
            default:
                pd_nxt = PD_IDLE;
        endcase
        if (switched)
        begin
            // reacquire without retuning, so the outputs keep their rate
            pd_nxt       = PD_IDLE;
            wcnt_nxt     = '0;
            good_nxt     = '0;
            unit_len_nxt = unit_len_r;
        end
        lock_nxt = good_nxt >= LW'(LOCK_COUNT);
    end
    function automatic logic [1:0] bank_pin(input logic lvl, input logic off,
                                            input mcb_pkg::mcb_level_t mode, input logic refl);
        if (mode == mcb_pkg::LVL_MID)
            bank_pin = {1'b1, refl};
        else if (off && mode == mcb_pkg::LVL_HIGH)
            bank_pin = 2'h0;
        else if (off)
            bank_pin = 2'h2;
        else
            bank_pin = {1'b1, lvl};
    endfunction

    wire [1:0]             off_bits = ctrl_r[mcb_pkg::CTRL_OFF_LSB +: 2];
    logic [9:0]            pin_out;
    logic [9:0]            pin_oe;
    generate
        for (gi = 0; gi < 10; gi++)
        begin : g_pin
            localparam int GRP = (gi < 2) ? 0 : (gi < 4) ? 1 : 2;
            assign {pin_oe[gi], pin_out[gi]} = bank_pin(level_g[GRP], off_bits[gi / 4 > 0 ? 1 : 0],
                                                        mode_lvl, ref_sel);
        end
    endgenerate
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r  <= mcb_pkg::CTRL_RESET;
            div_r   <= mcb_pkg::DIV_RESET;
            phase_r <= mcb_pkg::PHASE_RESET;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup_ph;
            prdata  <= setup_ph && !pwrite ? rd_sel : 32'h0000_0000;
            pslverr <= setup_ph & (~mapped | ro_write);
            if (wr_take && hit_ctrl)
                ctrl_r <= merge(ctrl_r, pwdata, pstrb, mcb_pkg::CTRL_MASK);
            if (wr_take && hit_div)
                div_r <= merge(div_r, pwdata, pstrb, mcb_pkg::DIV_MASK);
            if (wr_take && hit_phase)
                phase_r <= merge(phase_r, pwdata, pstrb, mcb_pkg::PHASE_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            unit_len_r    <= UNIT_LEN_W'(UNIT_LEN_INIT);
            ucnt_r        <= '0;
            wcnt_r        <= '0;
            good_r        <= '0;
            pd_r          <= PD_IDLE;
            loop_acquired <= 1'b0;
            ref_prev_r    <= 1'b0;
            ret_prev_r    <= 1'b0;
            choice_prev_r <= 1'b0;
            period_prev_r <= '0;
        end
        else
        begin
            unit_len_r    <= unit_len_nxt;
            ucnt_r        <= unit_tick ? '0 : ucnt_r + UNIT_LEN_W'(1);
            wcnt_r        <= wcnt_nxt;
            good_r        <= good_nxt;
            pd_r          <= pd_nxt;
            loop_acquired <= lock_nxt;
            ref_prev_r    <= ref_sel;
            ret_prev_r    <= loop_return_input;
            choice_prev_r <= choice;
            period_prev_r <= period_cat;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bank1_clock_outputs    <= 4'h0;
            bank1_clock_outputs_oe <= 4'h0;
            bank2_clock_outputs    <= 6'h00;
            bank2_clock_outputs_oe <= 6'h00;
            return_clock_output    <= 1'b0;
            return_clock_output_oe <= 1'b0;
        end
        else
        begin
            bank1_clock_outputs    <= pin_out[3:0];
            bank1_clock_outputs_oe <= pin_oe[3:0];
            bank2_clock_outputs    <= pin_out[9:4];
            bank2_clock_outputs_oe <= pin_oe[9:4];
            return_clock_output    <= (mode_lvl == mcb_pkg::LVL_MID) ? ref_sel : level_g[3];
            return_clock_output_oe <= 1'b1;
        end
    end

endmodule // mcb_clock_bank_ctrl

/* dv/mcb_clock_bank_ctrl_sva.sv */
`timescale 1ns/10ps
module mcb_clock_bank_ctrl_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  bank1_clock_outputs_oe,
    input wire logic [5:0]  bank2_clock_outputs_oe,
    input wire logic        return_clock_output_oe,
    input wire logic        loop_acquired
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [8:0] ctl_r;
    logic [1:0] age_r;
    wire logic wr = psel && penable && pready && pwrite && paddr == 8'h00;
    wire logic st = age_r == 2'h3;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {ctl_r, age_r} <= 11'h000;
        else
            {ctl_r, age_r} <= wr ? {pwdata[8:0], 2'h0} : {ctl_r, age_r + {1'b0, !st}};
    property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready");
    property p_err; psel && !penable && paddr > 8'h0C |=> pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped");
    property p_hiz; st && ctl_r[4:3] == 2'h2 && ctl_r[7] |-> bank1_clock_outputs_oe == 4'h0; endproperty
    a_hiz: assert property (p_hiz) else $error("hiz");
    property p_park; st && ctl_r[4:3] == 2'h0 && ctl_r[8] |-> bank2_clock_outputs_oe == 6'h3F; endproperty
    a_park: assert property (p_park) else $error("park");
    property p_on; st && !ctl_r[3] && !ctl_r[8] |-> bank2_clock_outputs_oe == 6'h3F; endproperty
    a_on: assert property (p_on) else $error("on");
    property p_test; st && ctl_r[3] |-> bank1_clock_outputs_oe == 4'hF; endproperty
    a_test: assert property (p_test) else $error("test");
    property p_ret; st |-> return_clock_output_oe; endproperty
    a_ret: assert property (p_ret) else $error("return");
    property p_lock; wr && pwdata[0] != ctl_r[0] |-> ##[1:3] !loop_acquired; endproperty
    a_lock: assert property (p_lock) else $error("lock");
endmodule // mcb_clock_bank_ctrl_sva
bind mcb_clock_bank_ctrl mcb_clock_bank_ctrl_sva u_sva (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pready, .pslverr, .bank1_clock_outputs_oe, .bank2_clock_outputs_oe, .return_clock_output_oe,
    .loop_acquired);

/* dv/mcb_board_model.sv */
`timescale 1ns/10ps
module mcb_board_model (
    input  wire logic stop_a,
    output logic      primary_reference_true,
    output logic      primary_reference_comp,
    output logic      secondary_reference_true,
    output logic      secondary_reference_comp,
    output logic      loop_return_input
);
    logic src = 1'b0;
    // one source, offset off the bench clock edges
    initial #3 forever #320 src = ~src;
    assign primary_reference_true = src & ~stop_a;
    assign primary_reference_comp = ~primary_reference_true;
    assign secondary_reference_true = src;
    assign secondary_reference_comp = 1'b1;
    assign loop_return_input = src;
endmodule // mcb_board_model

/* dv/mcb_clock_bank_ctrl_bench.sv */
`timescale 1ns/10ps
module mcb_clock_bank_ctrl_bench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stop_a = 1'b0, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [3:0] pstrb = 4'hF, bank1_clock_outputs, bank1_clock_outputs_oe;
    logic [5:0] bank2_clock_outputs, bank2_clock_outputs_oe;
    logic pready, pslverr, return_clock_output, return_clock_output_oe, loop_acquired, loop_return_input;
    logic primary_reference_true, primary_reference_comp, secondary_reference_true, secondary_reference_comp;
    wire logic [10:0] pins = {return_clock_output, bank2_clock_outputs, bank1_clock_outputs};
    int n_errors = 0, total_checks = 0, cyc = 0, n;
    int ratio [9] = '{1, 2, 3, 4, 5, 6, 8, 10, 12};
    logic [31:0] ctl [4] = '{32'h190, 32'h180, 32'h188, 32'h40};
    logic [10:0] en [4] = '{11'h400, 11'h7FF, 11'h7FF, 11'h7FF};
    always #5 pclk = ~pclk;
    always @(posedge pclk)
        if (++cyc > 40000)
            tally_and_finish(1);
    mcb_clock_bank_ctrl #(.EDGE_TIMEOUT(64)) dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .primary_reference_true, .primary_reference_comp,
        .secondary_reference_true, .secondary_reference_comp, .loop_return_input, .bank1_clock_outputs,
        .bank1_clock_outputs_oe, .bank2_clock_outputs, .bank2_clock_outputs_oe, .return_clock_output,
        .return_clock_output_oe, .loop_acquired);
    mcb_board_model board (.stop_a, .primary_reference_true, .primary_reference_comp,
        .secondary_reference_true, .secondary_reference_comp, .loop_return_input);
    task automatic tally_and_finish(input int late);
        n_errors += late;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        n_errors += int'(seen !== exp);
        if (seen !== exp)
            $display("Error %s expected %h seen %h", nm, exp, seen);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // cycles from a rise of pin a until pin b shows lvl
    task automatic gap(input int a, input int b, input logic lvl);
        wait (pins[a] === 1'b0);
        wait (pins[a] === 1'b1);
        #1;
        for (n = 0; pins[b] !== lvl && n < 4000; n++)
            #10;
    endtask
    function automatic logic [3:0] enc(input int k);
        return {2'(k / 3), 2'(k % 3)};
    endfunction
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, mcb_pkg::CTRL_OFS, 32'h0);
        chk("ctrl", q, mcb_pkg::CTRL_RESET);
        xfer(1'b0, 8'h10, 32'h0);
        chk("unmapped", {q[31:1], e}, 32'h1);
        wait (loop_acquired === 1'b1);
        xfer(1'b0, mcb_pkg::STATUS_OFS, 32'h0);
        chk("status", q[15:0], 16'h0801);
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b1, mcb_pkg::CTRL_OFS, ctl[i]);
            repeat (4) @(posedge pclk);
            chk("enables", {return_clock_output_oe, bank2_clock_outputs_oe, bank1_clock_outputs_oe}, en[i]);
        end
        // range high, unit of 8 cycles: half period is 32 cycles per ratio step
        for (int k = 0; k < 9; k++)
        begin
            xfer(1'b1, mcb_pkg::DIV_OFS, {20'h0, enc(k), enc(8 - k), enc(k)});
            repeat (4) @(posedge pclk);
            gap(0, 0, 1'b0);
            chk("bank1", n, 32 * ratio[k]);
            gap(4, 4, 1'b0);
            chk("bank2", n, 32 * ratio[8 - k]);
            gap(10, 10, 1'b0);
            chk("return", n, 32 * ratio[k]);
        end
        xfer(1'b1, mcb_pkg::DIV_OFS, 32'h0);
        xfer(1'b1, mcb_pkg::PHASE_OFS, 32'h0450);
        repeat (4) @(posedge pclk);
        gap(0, 2, 1'b1);
        chk("skew", n, 32);
        gap(0, 4, 1'b1);
        chk("copy", n, 0);
        gap(0, 10, 1'b1);
        chk("return skew", n, 0);
        xfer(1'b1, mcb_pkg::CTRL_OFS, 32'h45);
        xfer(1'b1, mcb_pkg::CTRL_OFS, 32'h40);
        stop_a <= 1'b1;
        wait (loop_acquired === 1'b0);
        repeat (600) @(posedge pclk);
        chk("unlocked", loop_acquired, 1'b0);
        xfer(1'b1, mcb_pkg::CTRL_OFS, 32'h45);
        wait (loop_acquired === 1'b1);
        xfer(1'b0, mcb_pkg::STATUS_OFS, 32'h0);
        chk("relock", {q[15:8] > 8'h08, q[0]}, 2'h3);
        tally_and_finish(0);
    end
endmodule // mcb_clock_bank_ctrl_bench
